// ### shared/tx_wait_frame_pkg.sv
// Register map, field layout and timing constants for the transmit wait and framing block
package tx_wait_frame_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WAIT_CONTROL = 8'h31;
  localparam logic [7:0] IDX_WAIT_LOW = 8'h32;
  localparam logic [7:0] IDX_FRAME_CONTROL = 8'h33;
  localparam logic [7:0] IDX_MODE_CONTROL = 8'h3E;
  localparam logic [7:0] IDX_STATUS = 8'h3F;
  localparam int ADDR_WIDTH = 10;
  // Wait-control fields
  localparam int WC_ORIGIN_BIT = 7;
  localparam int WC_UNIT_BIT = 6;
  localparam int WC_HIGH_MSB = 5;
  localparam int WC_HIGH_LSB = 3;
  localparam int WC_STOP_MSB = 2;
  localparam int WC_STOP_LSB = 0;
  // Frame-control fields
  localparam int FC_TX_PARITY_BIT = 7;
  localparam int FC_RX_PARITY_BIT = 6;
  localparam int FC_END_MSB = 3;
  localparam int FC_END_LSB = 2;
  localparam int FC_BEGIN_MSB = 1;
  localparam int FC_BEGIN_LSB = 0;
  localparam logic [7:0] FC_WRITE_MASK = 8'hCF;
  // Mode and status fields
  localparam int MODE_TYPE_B_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WAITING_BIT = 1;
  localparam int ST_PARITY_ERR_BIT = 2;
  // Reset values
  localparam logic [7:0] WAIT_CONTROL_RESET = 8'hC0;
  localparam logic [7:0] WAIT_LOW_RESET = 8'h00;
  localparam logic [7:0] FRAME_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  // Timing: carrier wait unit is 16 periods of 13.56 MHz
  localparam int CLOCK_PERIOD_PS = 25000;
  localparam int CARRIER_UNIT_PS = 1179941;
  localparam int CARRIER_UNIT_CYCLES = CARRIER_UNIT_PS / CLOCK_PERIOD_PS;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Kinds of transmitted item
  localparam logic [2:0] KIND_BEGIN = 3'h1;
  localparam logic [2:0] KIND_DATA = 3'h2;
  localparam logic [2:0] KIND_PARITY = 3'h3;
  localparam logic [2:0] KIND_STOP = 3'h4;
  localparam logic [2:0] KIND_GUARD = 3'h5;
  localparam logic [2:0] KIND_END = 3'h6;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;
endpackage : tx_wait_frame_pkg

// ### src/tx_wait_frame_config.sv
// Transmit wait timer, frame formatter, receive parity check and register slave
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps

module tx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  assign out_valid = count != '0;

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : tx_fifo

module tx_wait_frame_config (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [tx_wait_frame_pkg::ADDR_WIDTH-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [tx_wait_frame_pkg::ADDR_WIDTH-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST,
  input wire logic TX_DATA_VALID,
  output logic TX_DATA_READY,
  input wire logic HALF_BIT_TICK,
  output logic TX_ITEM_VALID,
  output logic [2:0] TX_ITEM_KIND,
  output logic TX_ITEM_BIT,
  output logic [1:0] TX_ITEM_SYMBOL,
  output logic TX_BUSY,
  input wire logic RX_END,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_PARITY,
  input wire logic RX_VALID,
  output logic [7:0] RX_OUT_DATA,
  output logic RX_OUT_VALID,
  output logic RX_PARITY_ERROR
);
  import tx_wait_frame_pkg::*;

  typedef enum {S_IDLE, S_BEGIN, S_FETCH, S_DATA, S_PARITY, S_STOP, S_GUARD, S_END} tx_state_type;

  logic [7:0] wait_control;
  logic [7:0] wait_low;
  logic [7:0] frame_control;
  logic [7:0] mode_control;
  logic parity_error_flag;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic aw_held;
  logic [7:0] w_byte;
  logic w_lane;
  logic w_held;
  logic [10:0] wait_remain;
  logic [5:0] prescale;
  logic half_phase;
  logic bit_tick;
  logic unit_tick;
  logic origin_event;
  logic tx_done;
  tx_state_type state;
  logic [7:0] shift;
  logic last_byte;
  logic [2:0] bit_index;
  logic [2:0] guard_left;
  logic [FIFO_WIDTH-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic wr_fire;
  logic wr_hit;

  // Register index from a byte address, 8'hFF when not word aligned
  function automatic logic [7:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
    return (addr[1:0] == 2'h0) ? addr[ADDR_WIDTH-1:2] : 8'hFF;
  endfunction : reg_index

  tx_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) data_fifo (
    .CLOCK(CLOCK),
    .RESETN(RESETN),
    .in_data({TX_LAST, TX_DATA}),
    .in_valid(TX_DATA_VALID),
    .in_ready(TX_DATA_READY),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Write channel: address and data taken in either order
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
  assign wr_hit = wr_fire && w_lane;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr <= S_AXI_AWADDR;
        aw_held <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_byte <= S_AXI_WDATA[7:0];
        w_lane <= S_AXI_WSTRB[0];
        w_held <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (reg_index(aw_addr) inside {IDX_WAIT_CONTROL, IDX_WAIT_LOW, IDX_FRAME_CONTROL,
          IDX_MODE_CONTROL, IDX_STATUS}) ? RESP_OKAY : RESP_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      wait_control <= WAIT_CONTROL_RESET;
      wait_low <= WAIT_LOW_RESET;
      frame_control <= FRAME_CONTROL_RESET;
      mode_control <= MODE_CONTROL_RESET;
    end else if (wr_hit) begin
      if (reg_index(aw_addr) == IDX_WAIT_CONTROL) begin
        wait_control <= w_byte;
      end else if (reg_index(aw_addr) == IDX_WAIT_LOW) begin
        wait_low <= w_byte;
      end else if (reg_index(aw_addr) == IDX_FRAME_CONTROL) begin
        frame_control <= w_byte & FC_WRITE_MASK;
      end else if (reg_index(aw_addr) == IDX_MODE_CONTROL) begin
        mode_control <= {7'h00, w_byte[MODE_TYPE_B_BIT]};
      end
    end
  end

  // Read channel
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= RESP_OKAY;
      if (reg_index(S_AXI_ARADDR) == IDX_WAIT_CONTROL) begin
        S_AXI_RDATA <= {24'h000000, wait_control};
      end else if (reg_index(S_AXI_ARADDR) == IDX_WAIT_LOW) begin
        S_AXI_RDATA <= {24'h000000, wait_low};
      end else if (reg_index(S_AXI_ARADDR) == IDX_FRAME_CONTROL) begin
        S_AXI_RDATA <= {24'h000000, frame_control};
      end else if (reg_index(S_AXI_ARADDR) == IDX_MODE_CONTROL) begin
        S_AXI_RDATA <= {24'h000000, mode_control};
      end else if (reg_index(S_AXI_ARADDR) == IDX_STATUS) begin
        S_AXI_RDATA <= {29'h0000000, parity_error_flag, wait_remain != 11'h000, TX_BUSY};
      end else begin
        S_AXI_RDATA <= 32'h0000_0000;
        S_AXI_RRESP <= RESP_SLVERR;
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Wait timer
  assign origin_event = wait_control[WC_ORIGIN_BIT] ? RX_END : tx_done;
  assign bit_tick = HALF_BIT_TICK && half_phase;
  assign unit_tick = wait_control[WC_UNIT_BIT] ? HALF_BIT_TICK
    : (prescale == 6'(CARRIER_UNIT_CYCLES - 1));

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      wait_remain <= 11'h000;
      prescale <= 6'h00;
      half_phase <= 1'b0;
    end else begin
      if (HALF_BIT_TICK) begin
        half_phase <= !half_phase;
      end
      if (origin_event) begin
        wait_remain <= {wait_control[WC_HIGH_MSB:WC_HIGH_LSB], wait_low};
        prescale <= 6'h00;
      end else begin
        prescale <= (prescale == 6'(CARRIER_UNIT_CYCLES - 1)) ? 6'h00 : prescale + 6'h01;
        if (unit_tick && wait_remain != 11'h000) begin
          wait_remain <= wait_remain - 11'h001;
        end
      end
    end
  end

  // Transmit framer
  assign fifo_pop = (state == S_FETCH) && fifo_valid;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state <= S_IDLE;
      shift <= 8'h00;
      last_byte <= 1'b0;
      bit_index <= 3'h0;
      guard_left <= 3'h0;
      tx_done <= 1'b0;
      TX_BUSY <= 1'b0;
      TX_ITEM_VALID <= 1'b0;
      TX_ITEM_KIND <= 3'h0;
      TX_ITEM_BIT <= 1'b0;
      TX_ITEM_SYMBOL <= 2'h0;
    end else begin
      tx_done <= 1'b0;
      TX_ITEM_VALID <= 1'b0;
      case (state)
        S_IDLE: begin
          if (fifo_valid && wait_remain == 11'h000 && !origin_event) begin
            TX_BUSY <= 1'b1;
            state <= (frame_control[FC_BEGIN_MSB:FC_BEGIN_LSB] != 2'h0) ? S_BEGIN : S_FETCH;
          end
        end
        S_BEGIN: begin
          if (bit_tick) begin
            TX_ITEM_VALID <= 1'b1;
            TX_ITEM_KIND <= KIND_BEGIN;
            TX_ITEM_SYMBOL <= frame_control[FC_BEGIN_MSB:FC_BEGIN_LSB] - 2'h1;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (fifo_valid) begin
            shift <= fifo_data[7:0];
            last_byte <= fifo_data[8];
            bit_index <= 3'h0;
            state <= S_DATA;
          end
        end
        S_DATA: begin
          if (bit_tick) begin
            TX_ITEM_VALID <= 1'b1;
            TX_ITEM_KIND <= KIND_DATA;
            TX_ITEM_BIT <= shift[bit_index];
            bit_index <= bit_index + 3'h1;
            if (bit_index == 3'h7) begin
              if (frame_control[FC_TX_PARITY_BIT]) begin
                state <= S_PARITY;
              end else if (mode_control[MODE_TYPE_B_BIT] && wait_control[WC_STOP_MSB:WC_STOP_LSB] != 3'h0) begin
                state <= S_STOP;
              end else begin
                state <= last_byte ? S_END : S_FETCH;
              end
            end
          end
        end
        S_PARITY: begin
          if (bit_tick) begin
            TX_ITEM_VALID <= 1'b1;
            TX_ITEM_KIND <= KIND_PARITY;
            TX_ITEM_BIT <= ~^shift;
            if (mode_control[MODE_TYPE_B_BIT] && wait_control[WC_STOP_MSB:WC_STOP_LSB] != 3'h0) begin
              state <= S_STOP;
            end else begin
              state <= last_byte ? S_END : S_FETCH;
            end
          end
        end
        S_STOP: begin
          if (bit_tick) begin
            TX_ITEM_VALID <= 1'b1;
            TX_ITEM_KIND <= KIND_STOP;
            TX_ITEM_BIT <= 1'b1;
            guard_left <= wait_control[WC_STOP_MSB:WC_STOP_LSB] - 3'h1;
            if (wait_control[WC_STOP_MSB:WC_STOP_LSB] != 3'h1) begin
              state <= S_GUARD;
            end else begin
              state <= last_byte ? S_END : S_FETCH;
            end
          end
        end
        S_GUARD: begin
          if (bit_tick) begin
            TX_ITEM_VALID <= 1'b1;
            TX_ITEM_KIND <= KIND_GUARD;
            TX_ITEM_BIT <= 1'b1;
            guard_left <= guard_left - 3'h1;
            if (guard_left == 3'h1) begin
              state <= last_byte ? S_END : S_FETCH;
            end
          end
        end
        S_END: begin
          if (frame_control[FC_END_MSB:FC_END_LSB] == 2'h0) begin
            tx_done <= 1'b1;
            TX_BUSY <= 1'b0;
            state <= S_IDLE;
          end else if (bit_tick) begin
            TX_ITEM_VALID <= 1'b1;
            TX_ITEM_KIND <= KIND_END;
            TX_ITEM_SYMBOL <= frame_control[FC_END_MSB:FC_END_LSB] - 2'h1;
            tx_done <= 1'b1;
            TX_BUSY <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Receive parity check; parity never reaches the receive data
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      RX_OUT_DATA <= 8'h00;
      RX_OUT_VALID <= 1'b0;
      RX_PARITY_ERROR <= 1'b0;
      parity_error_flag <= 1'b0;
    end else begin
      RX_OUT_VALID <= RX_VALID;
      RX_OUT_DATA <= RX_DATA;
      RX_PARITY_ERROR <= RX_VALID && frame_control[FC_RX_PARITY_BIT] && (RX_PARITY != ~^RX_DATA);
      if (RX_VALID && frame_control[FC_RX_PARITY_BIT] && (RX_PARITY != ~^RX_DATA)) begin
        parity_error_flag <= 1'b1;
      end else if (wr_hit && reg_index(aw_addr) == IDX_STATUS && w_byte[ST_PARITY_ERR_BIT]) begin
        parity_error_flag <= 1'b0;
      end
    end
  end

  // Checks
  no_start_wait_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (state == S_IDLE && wait_remain != 11'h000) |=> state == S_IDLE) else $error("frame started during wait");
  wait_load_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    origin_event |=> wait_remain == {$past(wait_control[5:3]), $past(wait_low)}) else $error("wait count not loaded");
  origin_rx_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (wait_control[7] && tx_done && !RX_END && wait_remain == 11'h000) |=> wait_remain == 11'h000)
    else $error("own frame end loaded wait in receive-origin mode");
  // Cycle age inside the current carrier unit, restarted at every origin event
  logic [5:0] unit_age;

  always_ff @(posedge CLOCK) begin
    if (!RESETN || origin_event || unit_age == 6'(CARRIER_UNIT_CYCLES - 1)) begin
      unit_age <= 6'h00;
    end else begin
      unit_age <= unit_age + 6'h01;
    end
  end

  carrier_unit_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (!wait_control[WC_UNIT_BIT] && !origin_event && wait_remain != 11'h000) |=>
    wait_remain == $past(wait_remain) - (($past(unit_age) == 6'(CARRIER_UNIT_CYCLES - 1)) ? 11'h001 : 11'h000))
    else $error("carrier wait unit wrong");
  half_bit_unit_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (wait_control[6] && HALF_BIT_TICK && !origin_event && wait_remain != 11'h000) |=> wait_remain == $past(wait_remain) - 11'h001)
    else $error("half-bit wait unit wrong");
  guard_units_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (TX_ITEM_VALID && TX_ITEM_KIND == KIND_STOP && wait_control[2:0] == 3'h1) |-> state != S_GUARD)
    else $error("guard sent with stop-length one");
  parity_value_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (TX_ITEM_VALID && TX_ITEM_KIND == KIND_PARITY) |-> TX_ITEM_BIT == ~^shift) else $error("tx parity wrong");
  rx_parity_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (RX_VALID && frame_control[6] && RX_PARITY == ~^RX_DATA) |=> !RX_PARITY_ERROR && RX_OUT_DATA == $past(RX_DATA))
    else $error("rx parity flagged wrongly");
  end_symbol_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (TX_ITEM_VALID && TX_ITEM_KIND == KIND_END) |-> TX_ITEM_SYMBOL == frame_control[3:2] - 2'h1)
    else $error("end symbol wrong");
  begin_symbol_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (TX_ITEM_VALID && TX_ITEM_KIND == KIND_BEGIN) |-> frame_control[FC_BEGIN_MSB:FC_BEGIN_LSB] != 2'h0 &&
    TX_ITEM_SYMBOL == frame_control[FC_BEGIN_MSB:FC_BEGIN_LSB] - 2'h1) else $error("begin symbol wrong");
  reset_value_a: assert property (@(posedge CLOCK)
    !RESETN |=> wait_control == 8'hC0) else $error("wait control reset value wrong");
  frame_done_c: cover property (@(posedge CLOCK) disable iff (!RESETN) tx_done);
  guard_sent_c: cover property (@(posedge CLOCK) disable iff (!RESETN) TX_ITEM_VALID && TX_ITEM_KIND == KIND_GUARD);
  rx_error_c: cover property (@(posedge CLOCK) disable iff (!RESETN) RX_PARITY_ERROR);
  fifo_full_c: cover property (@(posedge CLOCK) disable iff (!RESETN) !TX_DATA_READY);
endmodule : tx_wait_frame_config

// ### tb/card_model.sv
// Card-side model: logs transmitted items and answers with received bytes
`timescale 1ns/1ps
module card_model (
  input wire logic clock,
  input wire logic item_valid,
  input wire logic [2:0] item_kind,
  input wire logic item_bit,
  input wire logic [1:0] item_symbol,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_parity,
  output logic rx_end
);
  logic [5:0] items[$];
  int stamps[$];
  int cycle = 0;
  int end_at = 0;
  initial begin
    rx_valid = 1'h0;
    rx_data = 8'h00;
    rx_parity = 1'h0;
    rx_end = 1'h0;
  end
  always @(posedge clock) begin
    cycle <= cycle + 1;
    if (item_valid === 1'h1) begin
      items.push_back({item_kind, item_bit, item_symbol});
      stamps.push_back(cycle);
    end
  end
  // Called just after an edge; flip spoils the odd parity
  task automatic answer(input logic [7:0] b, input logic flip);
    rx_data <= b;
    rx_parity <= ~^b ^ flip;
    rx_valid <= 1'h1;
    @(posedge clock);
    rx_valid <= 1'h0;
    rx_data <= ~b;
    rx_parity <= ^b ^ flip;
    rx_end <= 1'h1;
    end_at = cycle;
    @(posedge clock);
    rx_end <= 1'h0;
  endtask : answer
endmodule : card_model

// ### tb/tb.sv
// Testbench for the transmit wait and framing block
`timescale 1ns/1ps
module tb;
  import tx_wait_frame_pkg::*;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic [9:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, tx_ready, it_valid, it_bit, tx_busy;
  logic [1:0] bresp, rresp, it_sym, tick_ph = 2'h0;
  logic [7:0] tx_data = 8'h00, rx_data, ro_data, got_data = 8'h00, d;
  logic tx_last = 1'h0, tx_valid = 1'h0, tick = 1'h0, tick_en = 1'h0, got_err = 1'h0;
  logic rx_end, rx_valid, rx_parity, ro_valid, ro_err;
  logic [2:0] it_kind;
  int fail_count = 0, check_count = 0, cycles = 0, base, gap, exp;
  always #12.5 clock = ~clock;
  tx_wait_frame_config dut (.CLOCK(clock), .RESETN(resetn), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_DATA_VALID(tx_valid), .TX_DATA_READY(tx_ready),
    .HALF_BIT_TICK(tick), .TX_ITEM_VALID(it_valid), .TX_ITEM_KIND(it_kind), .TX_ITEM_BIT(it_bit),
    .TX_ITEM_SYMBOL(it_sym), .TX_BUSY(tx_busy), .RX_END(rx_end), .RX_DATA(rx_data),
    .RX_PARITY(rx_parity), .RX_VALID(rx_valid), .RX_OUT_DATA(ro_data), .RX_OUT_VALID(ro_valid),
    .RX_PARITY_ERROR(ro_err));
  card_model card (.clock(clock), .item_valid(it_valid), .item_kind(it_kind), .item_bit(it_bit),
    .item_symbol(it_sym), .rx_valid(rx_valid), .rx_data(rx_data), .rx_parity(rx_parity),
    .rx_end(rx_end));
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  always @(posedge clock) begin
    cycles <= cycles + 1;
    tick_ph <= tick_ph + 2'h1;
    tick <= tick_en && tick_ph == 2'h3;
    if (ro_valid === 1'h1) begin
      got_data <= ro_data;
      got_err <= ro_err;
    end
    if (cycles == 40000) begin
      fail_count = fail_count + 1;
      results();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    check_count = check_count + 1;
    if (seen !== want) begin
      fail_count = fail_count + 1;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] resp);
    logic aw_done, w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clock);
      aw_done = aw_done | awready;
      w_done = w_done | wready;
      awvalid <= ~aw_done;
      wvalid <= ~w_done;
    end while (!(aw_done && w_done));
    do @(posedge clock); while (bvalid !== 1'h1);
    check("write response", bresp, resp);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] resp);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clock); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clock); while (rvalid !== 1'h1);
    check("read data", rdata, {24'h0, v});
    check("read response", rresp, resp);
  endtask : rdc
  // Leaves valid high so back-to-back bytes never re-assign it in one step
  task automatic push(input logic [7:0] v, input logic last);
    tx_data <= v;
    tx_last <= last;
    tx_valid <= 1'h1;
    do @(posedge clock); while (tx_ready !== 1'h1);
  endtask : push
  task automatic await_items(input int n);
    for (int i = 0; i < 20000 && card.items.size() < n; i++) @(posedge clock);
    repeat (16) @(posedge clock);
    check("item count", card.items.size(), n);
  endtask : await_items
  task automatic item(input int k, input logic [2:0] kind, input logic b, input logic [1:0] sym);
    logic [5:0] e;
    e = card.items[k];
    check("item kind", e[5:3], kind);
    if (kind == KIND_BEGIN || kind == KIND_END) check("item symbol", e[1:0], sym);
    else check("item bit", e[2], b);
  endtask : item
  task automatic reply(input logic [7:0] b, input logic flip, input logic err);
    card.answer(b, flip);
    @(posedge clock);
    check("rx data", got_data, b);
    check("rx parity error", got_err, err);
  endtask : reply
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'h1;
    rdc(IDX_WAIT_CONTROL, 8'hC0, RESP_OKAY);
    rdc(IDX_WAIT_LOW, 8'h00, RESP_OKAY);
    rdc(8'h30, 8'h00, RESP_SLVERR);
    wr(8'h30, 8'h55, RESP_SLVERR);
    wr(IDX_FRAME_CONTROL, 8'hFF, RESP_OKAY);
    rdc(IDX_FRAME_CONTROL, 8'hCF, RESP_OKAY);
    wr(IDX_MODE_CONTROL, 8'h01, RESP_OKAY);
    wr(IDX_WAIT_CONTROL, 8'h03, RESP_OKAY);
    wr(IDX_FRAME_CONTROL, 8'h8E, RESP_OKAY);
    // Ticks held off: the frame stalls and the buffer fills
    for (int k = 0; k < 8; k++) push(8'(8'h5A + 8'h29 * k), k == 7);
    tx_valid <= 1'h0;
    @(posedge clock);
    check("fifo ready", tx_ready, 1'h0);
    tick_en <= 1'h1;
    await_items(98);
    item(0, KIND_BEGIN, 1'h0, 2'h1);
    for (int k = 0; k < 8; k++) begin
      d = 8'(8'h5A + 8'h29 * k);
      for (int i = 0; i < 8; i++) item(1 + 12 * k + i, KIND_DATA, d[i], 2'h0);
      item(9 + 12 * k, KIND_PARITY, ~^d, 2'h0);
      item(10 + 12 * k, KIND_STOP, 1'h1, 2'h0);
      item(11 + 12 * k, KIND_GUARD, 1'h1, 2'h0);
      item(12 + 12 * k, KIND_GUARD, 1'h1, 2'h0);
    end
    item(97, KIND_END, 1'h0, 2'h2);
    // Every stop length and every symbol code, one byte per frame
    for (int c = 0; c < 8; c++) begin
      wr(IDX_WAIT_CONTROL, 8'(c), RESP_OKAY);
      wr(IDX_FRAME_CONTROL, 8'((((c + 1) % 4) << 2) | (c % 4)), RESP_OKAY);
      base = card.items.size();
      exp = base + ((c % 4) != 0) + 8 + (c != 0) + (c > 1 ? c - 1 : 0) + (((c + 1) % 4) != 0);
      push(8'hC3, 1'h1);
      tx_valid <= 1'h0;
      await_items(exp);
      if (c % 4 != 0) item(base, KIND_BEGIN, 1'h0, 2'((c % 4) - 1));
      if ((c + 1) % 4 != 0) item(exp - 1, KIND_END, 1'h0, 2'(((c + 1) % 4) - 1));
    end
    // Own-frame origin, carrier units, count 0x102
    wr(IDX_WAIT_CONTROL, 8'h08, RESP_OKAY);
    wr(IDX_WAIT_LOW, 8'h02, RESP_OKAY);
    wr(IDX_FRAME_CONTROL, 8'h01, RESP_OKAY);
    base = card.items.size();
    push(8'h96, 1'h1);
    push(8'h69, 1'h1);
    tx_valid <= 1'h0;
    repeat (2000) @(posedge clock);
    check("busy during wait", tx_busy, 1'h0);
    rdc(IDX_STATUS, 8'h02, RESP_OKAY);
    await_items(base + 18);
    gap = card.stamps[base + 9] - card.stamps[base + 8];
    check("carrier wait", gap >= 12126 && gap <= 12170, 1'h1);
    // Receive-end origin, half-bit units, count 5
    wr(IDX_WAIT_CONTROL, 8'hC0, RESP_OKAY);
    wr(IDX_WAIT_LOW, 8'h05, RESP_OKAY);
    wr(IDX_FRAME_CONTROL, 8'h41, RESP_OKAY);
    reply(8'hA5, 1'h0, 1'h0);
    reply(8'h3C, 1'h1, 1'h1);
    repeat (40) @(posedge clock);
    rdc(IDX_STATUS, 8'h04, RESP_OKAY);
    wr(IDX_STATUS, 8'h04, RESP_OKAY);
    rdc(IDX_STATUS, 8'h00, RESP_OKAY);
    wr(IDX_FRAME_CONTROL, 8'h01, RESP_OKAY);
    reply(8'hE7, 1'h1, 1'h0);
    base = card.items.size();
    card.answer(8'h5A, 1'h0);
    push(8'h81, 1'h1);
    tx_valid <= 1'h0;
    await_items(base + 9);
    gap = card.stamps[base] - card.end_at;
    check("half bit wait", gap >= 17 && gap <= 44, 1'h1);
    results();
  end
endmodule : tb
